// >>> src/smsf_pkg.sv
// Constants, states and carriers of the command status block
package smsf_pkg;
   // ==========================================================
   // Register port lanes
   localparam logic [1:0] ADDR_STS0 = 2'h0;  // Control/status bits
   localparam logic [1:0] ADDR_STS1 = 2'h1;  // Credit low byte
   localparam logic [1:0] ADDR_STS2 = 2'h2;  // Credit high byte
   localparam logic [1:0] ADDR_DATA = 2'h3;  // Data port
   // ==========================================================
   // Bit positions in lane 0
   localparam int BIT_VALID  = 7;  // Status valid
   localparam int BIT_READY  = 6;  // Ready request / ready state
   localparam int BIT_GO     = 5;  // Execute trigger
   localparam int BIT_PEND   = 4;  // Response pending
   localparam int BIT_EXPECT = 3;  // More bytes expected
   localparam int BIT_RETRY  = 1;  // Resend response
   // ==========================================================
   // Sizes and reset values
   localparam int CMD_DEPTH = 8;    // Command queue words
   localparam int RSP_DEPTH = 64;   // Response store bytes
   localparam int SIZE_FIRST = 2;   // First byte of size field
   localparam int SIZE_LAST  = 5;   // Last byte of size field
   localparam logic [7:0] IDLE_READ = 8'hff;  // Data read, no response
   // ==========================================================
   // Timing
   localparam int CLK_MHZ          = 10;    // clk_sys rate
   localparam int READY_TIMEOUT_US = 1000;  // Ready entry limit
   localparam int READY_TIMEOUT_CYC = READY_TIMEOUT_US * CLK_MHZ;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE, ST_PREP, ST_READY, ST_RECV, ST_EXEC, ST_DONE
   } smsf_state_e;
   typedef struct packed {
      logic [1:0] addr;   // Lane select
      logic       wr;     // Write strobe
      logic       rd;     // Read strobe
      logic [7:0] wdata;  // Write byte
   } smsf_req_s;
endpackage

// >>> src/smsf_top.sv
// Command status register, lifecycle machine and transfer credit
//
// Contract
// - Status writes need exactly one bit set.
// - Reception from first byte until execute trigger.
// - Execution until response pending or abort.
// - Completion holds until ready request written.
// - Idle after completion, locality change, abort; from completion a ready request goes to prepare instead.
// - Ready whenever a new command fits.
// - Credit field bits 23:8, read only.
// - Credit dynamic, tracks every byte moved.
// - Never wait for a full credit's worth.
// - Drain command bytes as they arrive.
// - Dynamic credit zero only full or empty.
// - Two credit bytes always form consistent count.
// - Low byte read latches high byte.
// - Pending counts readable, else writable bytes.
// - Ready request: prepare, abort, or free.
// - Completion request empties queues, ready or idle.
// - Ready only with empty queues.
// - Pending until last byte; resend replays.
// - Expect clears when size field satisfied.
`timescale 1ns/1ns

// ============================================================
// Command queue
module smsf_fifo #(
   parameter int W = 8,
   parameter int D = smsf_pkg::CMD_DEPTH
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 clr,
   input  wire logic                 in_valid,
   output logic                      in_ready,
   input  wire logic [W-1:0]         in_data,
   output logic                      out_valid,
   input  wire logic                 out_ready,
   output logic [W-1:0]              out_data,
   output logic [$clog2(D):0]        count
);
   localparam int AW = $clog2(D);
   // Refused at elaboration; pointers wrap on a power of two only
   if (D < 2 || (1 << AW) != D) begin
      $error("fifo depth must be a power of two");
   end
   logic [W-1:0]  mem_reg [D];    // Storage
   logic [AW:0]   wp_reg;         // Write pointer
   logic [AW:0]   rp_reg;         // Read pointer
   logic          push;
   logic          pop;
   assign count     = wp_reg - rp_reg;
   assign in_ready  = count != (AW+1)'(D);
   assign out_valid = count != '0;
   assign out_data  = mem_reg[rp_reg[AW-1:0]];
   assign push      = in_valid && in_ready && !clr;
   assign pop       = out_valid && out_ready && !clr;
   // Pointers; clear drops everything
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else if (clr) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_reg + (AW+1)'(push);
         rp_reg <= rp_reg + (AW+1)'(pop);
      end
   end
   // Storage needs no reset
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wp_reg[AW-1:0]] <= in_data;
      end
   end
endmodule

// ============================================================
// Top
module smsf_top #(
   parameter int RSP_DEPTH = smsf_pkg::RSP_DEPTH,
   parameter int READY_TIMEOUT_CYC = smsf_pkg::READY_TIMEOUT_CYC
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire smsf_pkg::smsf_req_s req,
   output logic [7:0]              rdata,
   output logic                    rdata_valid,
   output logic                    data_wr_ready,
   input  wire logic               loc_change,
   output logic                    cmd_valid,
   output logic [7:0]              cmd_data,
   input  wire logic               cmd_ready,
   output logic                    exec_start,
   output logic                    exec_abort,
   input  wire logic               rsp_valid,
   input  wire logic [7:0]         rsp_data,
   input  wire logic               rsp_last,
   output logic                    rsp_ready
);
   localparam int AW = $clog2(RSP_DEPTH);
   localparam int CW = $clog2(smsf_pkg::CMD_DEPTH);
   // Credit is 16 bits wide, so the store may not outgrow it
   if (RSP_DEPTH < 2 || RSP_DEPTH > 65535 || READY_TIMEOUT_CYC < 1) begin
      $error("unsupported parameter value");
   end

   smsf_pkg::smsf_state_e st_reg;        // Lifecycle state
   logic [7:0]  rsp_mem_reg [RSP_DEPTH];  // Response kept for replay
   logic [AW:0] rsp_len_reg;              // Bytes stored
   logic [AW:0] rd_ptr_reg;               // Next byte to return
   logic        pend_reg;                 // Response pending
   logic        expect_reg;               // More bytes expected
   logic [31:0] byte_cnt_reg;             // Command bytes received
   logic [31:0] size_reg;                 // Captured size field
   logic [31:0] tmo_reg;                  // Ready entry countdown
   logic [7:0]  hi_latch_reg;             // Latched credit high byte
   logic        latch_vld_reg;            // Latch holds a value
   logic        valid_reg;                // Status bits trustworthy
   logic [CW:0] cmd_count;
   logic        fifo_in_ready;
   logic [15:0] cred;
   logic        wr_sts, onehot, rr, go, retry;
   logic        data_wr, data_rd, accept_wr, flush;
   logic        rsp_take, rsp_done, last_rd;
   logic [31:0] size_now;                 // Size seen with current byte

   // ==========================================================
   // Decode
   assign wr_sts  = req.wr && req.addr == smsf_pkg::ADDR_STS0;
   assign onehot  = $onehot(req.wdata);
   assign rr      = wr_sts && onehot && req.wdata[smsf_pkg::BIT_READY];
   assign go      = wr_sts && onehot && req.wdata[smsf_pkg::BIT_GO];
   assign retry   = wr_sts && onehot && req.wdata[smsf_pkg::BIT_RETRY];
   assign data_wr = req.wr && req.addr == smsf_pkg::ADDR_DATA;
   assign data_rd = req.rd && req.addr == smsf_pkg::ADDR_DATA;
   // Bytes land only while a command may be written
   assign data_wr_ready = (st_reg == smsf_pkg::ST_READY ||
                           st_reg == smsf_pkg::ST_RECV) && fifo_in_ready;
   assign accept_wr = data_wr && data_wr_ready && !loc_change;
   // Ready request outside ready and prepare frees both queues
   assign flush = loc_change || (rr && st_reg != smsf_pkg::ST_READY &&
                                 st_reg != smsf_pkg::ST_PREP);
   assign rsp_ready = st_reg == smsf_pkg::ST_EXEC &&
                      rsp_len_reg != (AW+1)'(RSP_DEPTH);
   assign rsp_take  = rsp_valid && rsp_ready && !flush;
   assign rsp_done  = rsp_take && rsp_last;
   assign last_rd   = data_rd && pend_reg &&
                      rd_ptr_reg + (AW+1)'(1) == rsp_len_reg;

   // Queue drains to the engine as bytes arrive
   smsf_fifo #(.W(8), .D(smsf_pkg::CMD_DEPTH)) u_cmdq (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .clr       (flush),
      .in_valid  (accept_wr),
      .in_ready  (fifo_in_ready),
      .in_data   (req.wdata),
      .out_valid (cmd_valid),
      .out_ready (cmd_ready),
      .out_data  (cmd_data),
      .count     (cmd_count)
   );

   // ==========================================================
   // Lifecycle machine
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= smsf_pkg::ST_IDLE;
      end else if (loc_change) begin
         st_reg <= smsf_pkg::ST_IDLE;
      end else begin
         case (st_reg)
            smsf_pkg::ST_IDLE: begin
               if (rr) st_reg <= smsf_pkg::ST_PREP;
            end
            smsf_pkg::ST_PREP: begin
               // Enter ready only once both queues are empty
               if (cmd_count == '0 && rsp_len_reg == '0)
                  st_reg <= smsf_pkg::ST_READY;
               else if (tmo_reg == '0)
                  st_reg <= smsf_pkg::ST_IDLE;
            end
            smsf_pkg::ST_READY: begin
               // Ready request here is ignored
               if (accept_wr) st_reg <= smsf_pkg::ST_RECV;
            end
            smsf_pkg::ST_RECV: begin
               if (rr) st_reg <= smsf_pkg::ST_IDLE;
               else if (go) st_reg <= smsf_pkg::ST_EXEC;
            end
            smsf_pkg::ST_EXEC: begin
               if (rr) st_reg <= smsf_pkg::ST_IDLE;
               else if (rsp_done) st_reg <= smsf_pkg::ST_DONE;
            end
            smsf_pkg::ST_DONE: begin
               if (rr) st_reg <= smsf_pkg::ST_PREP;
            end
            default: st_reg <= smsf_pkg::ST_IDLE;
         endcase
      end
   end

   // Ready entry timeout, loaded on each request made outside prepare
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tmo_reg <= '0;
      end else if (rr && st_reg != smsf_pkg::ST_PREP) begin
         tmo_reg <= 32'(READY_TIMEOUT_CYC);
      end else if (tmo_reg != '0) begin
         tmo_reg <= tmo_reg - 32'h1;
      end
   end

   // Engine strobes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         exec_start <= 1'b0;
         exec_abort <= 1'b0;
      end else begin
         exec_start <= go && !loc_change && st_reg == smsf_pkg::ST_RECV;
         exec_abort <= flush && (st_reg == smsf_pkg::ST_RECV ||
                                 st_reg == smsf_pkg::ST_EXEC);
      end
   end

   // ==========================================================
   // Size tracking; size field is big endian
   // Only the last size byte is folded in live; later bytes are payload
   assign size_now = (byte_cnt_reg == 32'(smsf_pkg::SIZE_LAST)) ?
                     {size_reg[23:0], req.wdata} : size_reg;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         byte_cnt_reg <= '0;
         size_reg     <= '0;
         expect_reg   <= 1'b0;
      end else if (flush) begin
         byte_cnt_reg <= '0;
         size_reg     <= '0;
         expect_reg   <= 1'b0;
      end else if (st_reg == smsf_pkg::ST_PREP && cmd_count == '0 &&
                   rsp_len_reg == '0) begin
         byte_cnt_reg <= '0;
         expect_reg   <= 1'b1;
      end else if (accept_wr) begin
         byte_cnt_reg <= byte_cnt_reg + 32'h1;
         if (byte_cnt_reg >= 32'(smsf_pkg::SIZE_FIRST) &&
             byte_cnt_reg <= 32'(smsf_pkg::SIZE_LAST))
            size_reg <= {size_reg[23:0], req.wdata};
         // Clear once the byte count reaches the size field value
         if (byte_cnt_reg >= 32'(smsf_pkg::SIZE_LAST) &&
             byte_cnt_reg + 32'h1 >= size_now)
            expect_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Response store; kept whole so a resend can replay it
   always_ff @(posedge clk_sys) begin
      if (rsp_take) begin
         rsp_mem_reg[rsp_len_reg[AW-1:0]] <= rsp_data;
      end
   end

   // Fill level and read pointer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rsp_len_reg <= '0;
         rd_ptr_reg  <= '0;
      end else if (flush) begin
         rsp_len_reg <= '0;
         rd_ptr_reg  <= '0;
      end else begin
         if (rsp_take) rsp_len_reg <= rsp_len_reg + (AW+1)'(1);
         if (retry && st_reg == smsf_pkg::ST_DONE)
            rd_ptr_reg <= '0;
         else if (data_rd && pend_reg)
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
   end

   // Pending flag; a resend wins over a last read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= 1'b0;
      end else if (flush) begin
         pend_reg <= 1'b0;
      end else if (rsp_done ||
                   (retry && st_reg == smsf_pkg::ST_DONE)) begin
         pend_reg <= 1'b1;
      end else if (last_rd) begin
         pend_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Credit: true counter, moves with every byte
   always_comb begin
      if (pend_reg)
         cred = 16'(rsp_len_reg - rd_ptr_reg);
      else if (data_wr_ready || st_reg == smsf_pkg::ST_READY ||
               st_reg == smsf_pkg::ST_RECV)
         cred = 16'(smsf_pkg::CMD_DEPTH) - 16'(cmd_count);
      else
         cred = 16'h0;
   end

   // High byte latch; a data access drops it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hi_latch_reg  <= 8'h00;
         latch_vld_reg <= 1'b0;
      end else if (data_rd || data_wr) begin
         latch_vld_reg <= 1'b0;
      end else if (req.rd && req.addr == smsf_pkg::ADDR_STS1) begin
         hi_latch_reg  <= cred[15:8];
         latch_vld_reg <= 1'b1;
      end else if (req.rd && req.addr == smsf_pkg::ADDR_STS2) begin
         latch_vld_reg <= 1'b0;
      end
   end

   // Status becomes valid one cycle after reset release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) valid_reg <= 1'b0;
      else valid_reg <= 1'b1;
   end

   // ==========================================================
   // Read data, one cycle after the strobe; lanes separate
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata       <= 8'h00;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= req.rd;
         if (req.rd) begin
            case (req.addr)
               smsf_pkg::ADDR_STS0: begin
                  // Trigger and resend bits read as zero
                  rdata <= {valid_reg,
                            st_reg == smsf_pkg::ST_READY, 1'b0,
                            pend_reg, expect_reg, 3'h0};
               end
               smsf_pkg::ADDR_STS1: rdata <= cred[7:0];
               smsf_pkg::ADDR_STS2: begin
                  rdata <= latch_vld_reg ? hi_latch_reg
                                         : cred[15:8];
               end
               smsf_pkg::ADDR_DATA: begin
                  rdata <= pend_reg ? rsp_mem_reg[rd_ptr_reg[AW-1:0]]
                                    : smsf_pkg::IDLE_READ;
               end
               default: rdata <= 8'h00;
            endcase
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_onehot;
      wr_sts && !onehot && !loc_change && st_reg != smsf_pkg::ST_EXEC &&
      st_reg != smsf_pkg::ST_PREP |=> st_reg == $past(st_reg);
   endproperty
   a_onehot: assert property (p_onehot) else $error("bad write acted");
   property p_recv;
      st_reg == smsf_pkg::ST_READY && accept_wr |=>
      st_reg == smsf_pkg::ST_RECV ##0 cmd_count != '0 || cmd_ready;
   endproperty
   a_recv: assert property (p_recv) else $error("no reception");
   property p_exec;
      st_reg == smsf_pkg::ST_RECV && go && !rr && !loc_change |=>
      st_reg == smsf_pkg::ST_EXEC && exec_start;
   endproperty
   a_exec: assert property (p_exec) else $error("no execution");
   property p_hold;
      st_reg == smsf_pkg::ST_DONE && !rr && !loc_change |=>
      st_reg == smsf_pkg::ST_DONE;
   endproperty
   a_hold: assert property (p_hold) else $error("left completion");
   property p_idle;
      loc_change |=> st_reg == smsf_pkg::ST_IDLE && !pend_reg;
   endproperty
   a_idle: assert property (p_idle) else $error("no idle");
   property p_empty;
      st_reg == smsf_pkg::ST_READY |-> cmd_count == '0 &&
      rsp_len_reg == '0 && cred == 16'(smsf_pkg::CMD_DEPTH);
   endproperty
   a_empty: assert property (p_empty) else $error("ready not empty");
   property p_zero;
      !pend_reg && st_reg == smsf_pkg::ST_RECV && cred == 16'h0 |->
      !fifo_in_ready;
   endproperty
   a_zero: assert property (p_zero) else $error("false zero");
   property p_retry;
      st_reg == smsf_pkg::ST_DONE && retry && !loc_change |=>
      pend_reg && rd_ptr_reg == '0 && cred == 16'(rsp_len_reg);
   endproperty
   a_retry: assert property (p_retry) else $error("no replay");
   property p_latch;
      req.rd && req.addr == smsf_pkg::ADDR_STS1 && !req.wr ##1
      !req.rd && !req.wr ##1
      req.rd && req.addr == smsf_pkg::ADDR_STS2 |=>
      rdata == $past(hi_latch_reg);
   endproperty
   a_latch: assert property (p_latch) else $error("torn credit");
   property p_free;
      st_reg == smsf_pkg::ST_DONE && rr && !loc_change |=>
      cmd_count == '0 && rsp_len_reg == '0 && st_reg == smsf_pkg::ST_PREP;
   endproperty
   a_free: assert property (p_free) else $error("queues kept");

   c_exec:  cover property (st_reg == smsf_pkg::ST_EXEC);
   c_done:  cover property (st_reg == smsf_pkg::ST_DONE && last_rd);
   c_retry: cover property (st_reg == smsf_pkg::ST_DONE && retry);
   c_abort: cover property (exec_abort);
endmodule

// >>> test/secure_module_status_fsm_tb_top.sv
// Self-checking bench of the command status block
`timescale 1ns/1ns
module secure_module_status_fsm_tb_top;
   logic clk_sys, rst_n, loc_change, hold_cmd, slow;
   logic [7:0] rsp_len, rdata, cmd_data, rsp_data, q;
   smsf_pkg::smsf_req_s req;
   logic rdata_valid, data_wr_ready, cmd_valid, cmd_ready, exec_start;
   logic exec_abort, rsp_valid, rsp_last, rsp_ready;
   int   failures, samples_checked, n_start, n_abort, base;
   logic [7:0] cmd [0:9];  // Command under test

   smsf_top #(.READY_TIMEOUT_CYC(20)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
      .rdata_valid(rdata_valid), .data_wr_ready(data_wr_ready),
      .loc_change(loc_change), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .exec_start(exec_start), .exec_abort(exec_abort),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_last(rsp_last), .rsp_ready(rsp_ready));
   smsf_engine_model eng_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .hold_cmd(hold_cmd),
      .slow(slow), .rsp_len(rsp_len), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .exec_start(exec_start), .exec_abort(exec_abort),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_last(rsp_last), .rsp_ready(rsp_ready));

   // ==========================================================
   // Clock 10 MHz and pulse counters
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (exec_start === 1'b1) n_start++;
      if (exec_abort === 1'b1) n_abort++;
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [15:0] seen, exp, input string m);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t %s seen %h exp %h", $time, m, seen, exp);
      end
   endtask
   // One register access; strobes held over exactly one sampling edge
   task automatic acc(input logic [1:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      #1 req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk_sys);
      #1 req.wr = 1'b0;
      req.rd = 1'b0;
      q = rdata;
      check(rdata_valid, !w, "read answer");
   endtask
   // Poll a lane0 bit with a bound; each poll read still checks the read answer
   task automatic poll(input int b, input logic v);
      int n;
      n = 0;
      do begin
         acc(2'h0, 1'b0, 8'h00);
         n++;
      end while (q[b] !== v && n < 200);
   endtask
   function automatic logic [7:0] rsp_byte(input int i);
      return 8'h5a ^ i[7:0];  // Engine response pattern
   endfunction
   task automatic give_verdict;
      $display("failures %0d samples_checked %0d", failures,
               samples_checked);
      if (failures == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far above the expected run length
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      give_verdict;
   end

   // ==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0; req = '0; loc_change = 1'b0; hold_cmd = 1'b0;
      slow = 1'b0; rsp_len = 8'h04;
      failures = 0; samples_checked = 0; n_start = 0; n_abort = 0;
      void'($urandom(61));
      repeat (8) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      acc(2'h0, 1'b0, 8'h00); check(q, 8'h80, "idle after reset");
      // Multi-bit, zero and misplaced trigger writes all do nothing
      acc(2'h0, 1'b1, 8'h60); acc(2'h0, 1'b1, 8'h00);
      acc(2'h0, 1'b1, 8'h20); acc(2'h0, 1'b0, 8'h00);
      check(q, 8'h80, "ignored writes");
      check(n_start, 0, "trigger outside reception");
      for (int r = 0; r < 2; r++) begin
         slow = r[0];
         acc(2'h0, 1'b1, 8'h40); poll(6, 1'b1);
         check(q, 8'hc8, "ready with expect");
         acc(2'h1, 1'b0, 8'h00); check(q, 8'h08, "write credit");
         acc(2'h2, 1'b0, 8'h00); check(q, 8'h00, "credit high");
         foreach (cmd[i]) cmd[i] = $urandom();
         cmd[2] = 8'h00; cmd[3] = 8'h00; cmd[4] = 8'h00; cmd[5] = 8'h0a;
         base = eng_u.got_n;
         hold_cmd = 1'b1;
         acc(2'h3, 1'b1, cmd[0]); acc(2'h0, 1'b0, 8'h00);
         check(q, 8'h88, "reception clears ready");
         for (int i = 1; i < 8; i++) acc(2'h3, 1'b1, cmd[i]);
         acc(2'h1, 1'b0, 8'h00); check(q, 8'h00, "full queue credit");
         check(data_wr_ready, 1'b0, "full refuses");
         hold_cmd = 1'b0;
         repeat (12) @(posedge clk_sys);
         acc(2'h1, 1'b0, 8'h00); check(q, 8'h08, "queue drained");
         acc(2'h3, 1'b1, cmd[8]); acc(2'h0, 1'b0, 8'h00);
         check(q, 8'h88, "expect before last");
         acc(2'h3, 1'b1, cmd[9]); acc(2'h0, 1'b0, 8'h00);
         check(q, 8'h80, "expect after last");
         repeat (4) @(posedge clk_sys);
         foreach (cmd[i]) check(eng_u.got[base+i], cmd[i], "cmd byte");
         rsp_len = 8'h03 + 8'($urandom_range(6));
         acc(2'h0, 1'b1, 8'h20);
         poll(4, 1'b1); check(q, 8'h90, "completion");
         check(n_start, r + 1, "execute start");
         acc(2'h1, 1'b0, 8'h00); check(q, rsp_len, "read credit");
         acc(2'h2, 1'b0, 8'h00); check(q, 8'h00, "latched high");
         for (int i = 0; i < 2; i++) begin
            acc(2'h3, 1'b0, 8'h00); check(q, rsp_byte(i), "rsp byte");
         end
         acc(2'h1, 1'b0, 8'h00); check(q, rsp_len - 8'h02, "credit");
         acc(2'h0, 1'b1, 8'h02);
         acc(2'h1, 1'b0, 8'h00); check(q, rsp_len, "resend credit");
         for (int i = 0; i < rsp_len; i++) begin
            acc(2'h3, 1'b0, 8'h00); check(q, rsp_byte(i), "replay");
         end
         acc(2'h0, 1'b0, 8'h00); check(q, 8'h80, "pending cleared");
         acc(2'h3, 1'b0, 8'h00); check(q, smsf_pkg::IDLE_READ, "drained");
         acc(2'h0, 1'b1, 8'h40); poll(6, 1'b1);
         check(q, 8'hc8, "freed then ready");
         acc(2'h1, 1'b0, 8'h00); check(q, 8'h08, "queues empty");
      end
      // Abort in reception, then a locality change in ready
      acc(2'h3, 1'b1, 8'h11); acc(2'h0, 1'b1, 8'h40);
      repeat (2) @(posedge clk_sys);
      check(n_abort, 1, "abort pulse");
      acc(2'h0, 1'b0, 8'h00); check(q, 8'h80, "idle after abort");
      acc(2'h0, 1'b1, 8'h40); poll(6, 1'b1);
      loc_change = 1'b1;
      @(posedge clk_sys);
      #1 loc_change = 1'b0;
      acc(2'h0, 1'b0, 8'h00); check(q, 8'h80, "idle after locality");
      give_verdict;
   end
endmodule

// >>> test/smsf_engine_model.sv
// Command engine model: takes command bytes, answers with a response
`timescale 1ns/1ns
module smsf_engine_model (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       hold_cmd,   // Stall command intake
   input  wire logic       slow,       // Insert gaps between bytes
   input  wire logic [7:0] rsp_len,    // Response length, at least 1
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_data,
   output logic            cmd_ready,
   input  wire logic       exec_start,
   input  wire logic       exec_abort,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_last,
   input  wire logic       rsp_ready
);
   logic [7:0] got [0:63];  // Command bytes in arrival order
   int         got_n;       // Bytes taken so far
   logic       active;      // Response in progress
   logic [7:0] idx;         // Next response byte
   logic [1:0] gap;         // Cycles before next byte

   // Intake follows the stall input only
   assign cmd_ready = !hold_cmd;

   // ==========================================================
   // Intake and response generation
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         active    <= 1'b0;
         idx       <= 8'h00;
         gap       <= 2'h0;
         got_n     <= 0;
         rsp_valid <= 1'b0;
         rsp_last  <= 1'b0;
         rsp_data  <= 8'h00;
      end else begin
         // Idle data toggles so a stale byte never looks valid
         if (!rsp_valid) rsp_data <= ~rsp_data;
         if (cmd_valid && cmd_ready) begin
            got[got_n] <= cmd_data;
            got_n      <= got_n + 1;
         end
         if (exec_start) begin
            active <= 1'b1;
            idx    <= 8'h00;
            gap    <= slow ? 2'h3 : 2'h0;
         end else if (exec_abort) begin
            active    <= 1'b0;
            rsp_valid <= 1'b0;
         end else if (rsp_valid && rsp_ready) begin
            // Byte taken; drop it, hold nothing past the handshake
            rsp_valid <= 1'b0;
            rsp_last  <= 1'b0;
            rsp_data  <= ~rsp_data;
            idx       <= idx + 8'h01;
            gap       <= slow ? 2'h2 : 2'h0;
            if (rsp_last) active <= 1'b0;
         end else if (active && !rsp_valid) begin
            if (gap != 2'h0) gap <= gap - 2'h1;
            else begin
               rsp_valid <= 1'b1;
               rsp_data  <= 8'h5a ^ idx;
               rsp_last  <= (idx == rsp_len - 8'h01);
            end
         end
      end
   end
endmodule
